//--- shared/vpt_pkg.sv
/*
 Package for the amplifier power and termination configuration block.
 Holds register offsets, field positions, reset values, power profile codes
 and the carrier structs shared by the register bank and the term decoder.
 Assumes a 32-bit APB master and a 100 MHz system clock.
*/
package vpt_pkg;

    // Register word indices and the byte addresses built from them
    localparam logic [7:0]  PWR_CTRL_IDX     = 8'hC5;
    localparam logic [7:0]  TERM_CTRL_IDX    = 8'hC4;
    localparam logic [7:0]  SCOPE_CTRL_IDX   = 8'hC7;
    localparam logic [7:0]  DIE_STATE_IDX    = 8'hC8;
    localparam logic [11:0] PWR_CTRL_ADDR    = {2'h0, PWR_CTRL_IDX, 2'h0};
    localparam logic [11:0] TERM_CTRL_ADDR   = {2'h0, TERM_CTRL_IDX, 2'h0};
    localparam logic [11:0] SCOPE_CTRL_ADDR  = {2'h0, SCOPE_CTRL_IDX, 2'h0};
    localparam logic [11:0] DIE_STATE_ADDR   = {2'h0, DIE_STATE_IDX, 2'h0};

    // Power-control word field positions
    localparam int FULL_SLEEP_BIT  = 15;
    localparam int QUICK_SLEEP_BIT = 14;
    localparam int PREAMP_OFF_BIT  = 13;
    localparam int ATTEN_OFF_BIT   = 12;
    localparam int PROFILE_HI_BIT  = 11;
    localparam int PROFILE_LO_BIT  = 10;
    localparam int QUIET_BIT       = 9;
    localparam int RSVD_BIT        = 8;
    localparam int PAIR_HI_BIT     = 7;
    localparam int NUM_PAIRS       = 8;
    localparam int NUM_CHAN        = 16;

    // Termination word field positions
    localparam int TERM_EN_BIT     = 5;
    localparam int TERM_CODE_HI    = 4;
    localparam int GAIN_LO_BIT     = 13;
    localparam int GAIN_HI_BIT     = 14;

    // Reset values
    localparam logic [15:0] PWR_CTRL_RESET  = 16'h0000;
    localparam logic [15:0] TERM_CTRL_RESET = 16'h0000;
    localparam logic [4:0]  TERM_HIGHZ      = 5'h00;

    // Power profile codes
    localparam logic [1:0] PROFILE_LOW_NOISE = 2'h0;
    localparam logic [1:0] PROFILE_LOW_POWER = 2'h1;
    localparam logic [1:0] PROFILE_MED_POWER = 2'h2;
    localparam logic [1:0] PROFILE_RESERVED  = 2'h3;

    // Preamp gain codes
    localparam logic [1:0] GAIN_18DB = 2'h0;
    localparam logic [1:0] GAIN_24DB = 2'h1;
    localparam logic [1:0] GAIN_12DB = 2'h2;

    // Per-die amplifier control
    typedef struct packed {
        logic       full_sleep;
        logic       quick_sleep;
        logic       preamp_off;
        logic       atten_gain_stage_off;
        logic [1:0] power_profile;
        logic       quiet_input_option;
    } vpt_die_ctrl_type;

    // Termination request toward the decoder
    typedef struct packed {
        logic       enable;
        logic [1:0] gain;
        logic [4:0] code;
    } vpt_term_req_type;

    // Decoded termination selection
    typedef struct packed {
        logic       high_z;
        logic       active;
        logic [1:0] gain_row;
        logic [4:0] code;
    } vpt_term_sel_type;

endpackage : vpt_pkg

//--- hw/vpt_term_decode.sv
/*
 Termination decoder: turns the 5-bit code and the preamp gain setting into
 one of 32 x 3 resistor selections, registered.
 Assumes the gain code comes from the termination word of the register bank.
*/
`timescale 1ns/10ps
module vpt_term_decode
    import vpt_pkg::*;
(
    // Clock and reset
    input  wire logic             sys_clk_i,
    input  wire logic             rst_i,
    // Request and selection
    input  wire vpt_term_req_type req_i,
    output vpt_term_sel_type      sel_o
);

    typedef struct packed {
        vpt_term_sel_type sel;
    } vpt_td_state_type;

    vpt_td_state_type state;
    vpt_td_state_type next_state;

    // Decode code against gain; code zero or disabled means high impedance
    always_comb
    begin
        next_state = state;
        next_state.sel.active   = req_i.enable;
        next_state.sel.code     = req_i.enable ? req_i.code : TERM_HIGHZ;
        next_state.sel.gain_row = req_i.gain;
        next_state.sel.high_z   = !req_i.enable || (req_i.code == TERM_HIGHZ);
        if (rst_i)
        begin
            next_state = '0;
            next_state.sel.high_z = 1'b1;
        end
    end

    // State register
    always_ff @(posedge sys_clk_i)
    begin
        state <= next_state;
    end

    assign sel_o = state.sel;

endmodule : vpt_term_decode

//--- hw/vpt_power_cfg.sv
/*
 Register bank for amplifier-die power and termination control, APB slave.
 Assumes an APB master on sys_clk_i; analog power controls leave as levels.
*/
// The APB interface to the registers is this design's own decision.
`timescale 1ns/10ps
module vpt_power_cfg
    import vpt_pkg::*;
(
    // Clock and reset
    input  wire logic                    sys_clk_i,
    input  wire logic                    rst_i,
    // APB slave
    input  wire logic                    psel_i,
    input  wire logic                    penable_i,
    input  wire logic                    pwrite_i,
    input  wire logic [11:0]             paddr_i,
    input  wire logic [31:0]             pwdata_i,
    output logic [31:0]                  prdata_o,
    output logic                         pready_o,
    output logic                         pslverr_o,
    // Amplifier die controls
    output vpt_die_ctrl_type             die1_ctrl_o,
    output vpt_die_ctrl_type             die2_ctrl_o,
    // Per-channel amplifier power-down, bit n is channel n+1
    output logic [NUM_CHAN-1:0]          chan_off_o,
    // Converter power, always on
    output logic                         adc_power_on_o,
    // Termination selection
    output vpt_term_sel_type             term_sel_o
);

    typedef struct packed {
        logic [15:0]          pwr_ctrl;
        logic [15:0]          term_ctrl;
        logic                 die_scope_select;
        vpt_die_ctrl_type     die1;
        vpt_die_ctrl_type     die2;
        logic [NUM_CHAN-1:0]  chan_off;
        logic                 adc_on;
        logic [31:0]          rdata;
        logic                 ready;
        logic                 slverr;
    } vpt_state_type;

    vpt_state_type        state;
    vpt_state_type        next_state;
    vpt_die_ctrl_type     die_cmd;
    logic [NUM_CHAN-1:0]  chan_cmd;
    logic                 access;
    logic                 addr_hit;
    vpt_term_req_type     term_req;

    // Die command from the power-control word; full sleep masks quick sleep
    always_comb
    begin
        die_cmd.full_sleep           = state.pwr_ctrl[FULL_SLEEP_BIT];
        die_cmd.quick_sleep          = state.pwr_ctrl[QUICK_SLEEP_BIT]
                                       && !state.pwr_ctrl[FULL_SLEEP_BIT];
        die_cmd.preamp_off           = state.pwr_ctrl[PREAMP_OFF_BIT];
        die_cmd.atten_gain_stage_off = state.pwr_ctrl[ATTEN_OFF_BIT];
        die_cmd.power_profile        = state.pwr_ctrl[PROFILE_HI_BIT:PROFILE_LO_BIT];
        die_cmd.quiet_input_option   = state.pwr_ctrl[QUIET_BIT];
    end

    // Channel pair decode: lower channel of each pair only when both dies scoped
    generate
        for (genvar p = 0; p < NUM_PAIRS; p++)
        begin : g_pair
            assign chan_cmd[2*p+1] = state.pwr_ctrl[p];
            assign chan_cmd[2*p]   = state.pwr_ctrl[p] && !state.die_scope_select;
        end
    endgenerate

    // Termination request to the decoder
    always_comb
    begin
        term_req.enable = state.term_ctrl[TERM_EN_BIT];
        term_req.gain   = state.term_ctrl[GAIN_HI_BIT:GAIN_LO_BIT];
        term_req.code   = state.term_ctrl[TERM_CODE_HI:0];
    end

    // APB decode
    assign access   = psel_i && penable_i && !state.ready;
    assign addr_hit = (paddr_i == PWR_CTRL_ADDR) || (paddr_i == TERM_CTRL_ADDR)
                      || (paddr_i == SCOPE_CTRL_ADDR) || (paddr_i == DIE_STATE_ADDR);

    // Next state: bus access, register writes and output staging
    always_comb
    begin
        next_state        = state;
        next_state.ready  = access;
        next_state.slverr = access && !addr_hit;
        next_state.rdata  = 32'h0000_0000;
        if (access && pwrite_i)
        begin
            unique case (paddr_i)
                PWR_CTRL_ADDR:
                begin
                    next_state.pwr_ctrl = pwdata_i[15:0];
                    next_state.pwr_ctrl[RSVD_BIT] = 1'b0;
                    // Quiet option held unless profile is low noise
                    if (state.pwr_ctrl[PROFILE_HI_BIT:PROFILE_LO_BIT] != PROFILE_LOW_NOISE)
                    begin
                        next_state.pwr_ctrl[QUIET_BIT] = state.pwr_ctrl[QUIET_BIT];
                    end
                end
                TERM_CTRL_ADDR:
                begin
                    next_state.term_ctrl = pwdata_i[15:0];
                end
                SCOPE_CTRL_ADDR:
                begin
                    next_state.die_scope_select = pwdata_i[0];
                end
                default:
                begin
                    next_state.pwr_ctrl = state.pwr_ctrl;
                end
            endcase
        end
        else if (access)
        begin
            unique case (paddr_i)
                PWR_CTRL_ADDR:   next_state.rdata = {16'h0000, state.pwr_ctrl};
                TERM_CTRL_ADDR:  next_state.rdata = {16'h0000, state.term_ctrl};
                SCOPE_CTRL_ADDR: next_state.rdata = {31'h0000_0000, state.die_scope_select};
                DIE_STATE_ADDR:  next_state.rdata = {18'h00000, state.die2, state.die1};
                default:         next_state.rdata = 32'h0000_0000;
            endcase
        end
        // Die 1 always follows; die 2 only when both dies are scoped
        next_state.die1 = die_cmd;
        next_state.die2 = state.die_scope_select ? '0 : die_cmd;
        next_state.chan_off = chan_cmd;
        next_state.adc_on   = 1'b1;
        if (rst_i)
        begin
            next_state = '0;
            next_state.pwr_ctrl  = PWR_CTRL_RESET;
            next_state.term_ctrl = TERM_CTRL_RESET;
            next_state.adc_on    = 1'b1;
        end
    end

    // State register
    always_ff @(posedge sys_clk_i)
    begin
        state <= next_state;
    end

    // Termination decoder
    vpt_term_decode u_term_decode (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .req_i     (term_req),
        .sel_o     (term_sel_o)
    );

    // Outputs straight from flops
    assign prdata_o       = state.rdata;
    assign pready_o       = state.ready;
    assign pslverr_o      = state.slverr;
    assign die1_ctrl_o    = state.die1;
    assign die2_ctrl_o    = state.die2;
    assign chan_off_o     = state.chan_off;
    assign adc_power_on_o = state.adc_on;

endmodule : vpt_power_cfg

//--- bench/vpt_host_model.sv
/* Host model: APB master making one transfer per xfer call.
 Assumes the bench calls xfer from one process at a time. */
`timescale 1ns/10ps
module vpt_host_model
    import vpt_pkg::*;
(
    // Clock
    input  wire logic   sys_clk_i,
    // APB master side
    output logic        psel_o,
    output logic        penable_o,
    output logic        pwrite_o,
    output logic [11:0] paddr_o,
    output logic [31:0] pwdata_o,
    input  wire logic   pready_i
);
    // Bus idle at time zero
    initial {psel_o, penable_o, pwrite_o, paddr_o, pwdata_o} = '0;

    // Random idle gap, setup, access held until ready
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        repeat (1 + $urandom_range(2)) @(posedge sys_clk_i);
        psel_o   <= 1'b1;
        pwrite_o <= wr;
        paddr_o  <= a;
        pwdata_o <= (a == PWR_CTRL_ADDR) ? (d & 32'hFFFF_FEFF) : d;
        @(posedge sys_clk_i);
        penable_o <= 1'b1;
        do @(posedge sys_clk_i); while (pready_i !== 1'b1);
        psel_o    <= 1'b0;
        penable_o <= 1'b0;
        pwdata_o  <= ~pwdata_o; // Stale data never looks valid
    endtask : xfer
endmodule : vpt_host_model

//--- bench/vpt_power_cfg_monitor.sv
/* Assertion checker for the power config bank.
 Sees only the bank's ports; bound in at the foot. */
`timescale 1ns/10ps
module vpt_power_cfg_monitor
    import vpt_pkg::*;
(
    // Clock, reset and bus
    input wire logic             sys_clk_i,
    input wire logic             rst_i,
    input wire logic             psel_i,
    input wire logic             penable_i,
    input wire logic             pwrite_i,
    input wire logic [31:0]      prdata_o,
    input wire logic             pready_o,
    input wire logic             pslverr_o,
    // Controls
    input wire vpt_die_ctrl_type die1_ctrl_o,
    input wire vpt_die_ctrl_type die2_ctrl_o,
    input wire logic [15:0]      chan_off_o,
    input wire logic             adc_power_on_o,
    input wire vpt_term_sel_type term_sel_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    a_adc_stays_on: assert property (adc_power_on_o)
        else $error("converter power dropped");
    a_full_beats_quick: assert property (
        die1_ctrl_o.full_sleep |-> !die1_ctrl_o.quick_sleep)
        else $error("quick sleep shown under full sleep");
    a_die2_follows: assert property (die2_ctrl_o != 7'h00 |-> die2_ctrl_o == die1_ctrl_o)
        else $error("second die differs from first");
    a_pair_upper: assert property ((chan_off_o[14:0] & ~chan_off_o[15:1] & 15'h5555) == 15'h0)
        else $error("lower channel off without upper");
    a_reset_clear: assert property (disable iff (1'b0)
        rst_i ##1 rst_i |=> die1_ctrl_o == 7'h00 && chan_off_o == 16'h0000)
        else $error("controls not cleared by reset");
    a_term_active: assert property (
        !term_sel_o.active |-> term_sel_o.high_z && term_sel_o.code == 5'h00)
        else $error("disabled termination not high impedance");
    a_term_zero_hiz: assert property (term_sel_o.code == 5'h00 |-> term_sel_o.high_z)
        else $error("code zero without high impedance");
    a_ready_after_take: assert property (psel_i && penable_i && !pready_o |=> pready_o)
        else $error("ready late");
    a_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("ready longer than one cycle");
    a_err_reads_zero: assert property (pslverr_o |-> pready_o && prdata_o == 32'h0)
        else $error("error without ready or with data");
    a_chan_after_write: assert property (
        !$stable(chan_off_o) |-> ($past(pready_o) && $past(pwrite_i))
        || ($past(pready_o, 2) && $past(pwrite_i, 2)))
        else $error("channel power changed without a write");
endmodule : vpt_power_cfg_monitor

bind vpt_power_cfg vpt_power_cfg_monitor mon (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .die1_ctrl_o(die1_ctrl_o),
    .die2_ctrl_o(die2_ctrl_o), .chan_off_o(chan_off_o), .adc_power_on_o(adc_power_on_o),
    .term_sel_o(term_sel_o));

//--- bench/tb_top.sv
/* Top bench: host model drives the bank, reads checked from a queue.
 Assumes outputs settle within four cycles of a completed write. */
`timescale 1ns/10ps
module tb_top
    import vpt_pkg::*;
;
    // Wires, notes and counters
    logic             sys_clk_i, rst_i, psel, penable, pwrite, pready, pslverr, adc_on;
    logic [11:0]      paddr;
    logic [31:0]      pwdata, prdata;
    vpt_die_ctrl_type die1, die2, e1, e2;
    vpt_term_sel_type term_sel;
    logic [15:0]      chan_off, w, ec;
    logic [33:0]      notes[$];
    logic [33:0]      n;
    logic [15:0]      tbl[6] = '{16'hC000, 16'h4000, 16'h2200, 16'h1000, 16'h0400, 16'h0A00};
    logic [4:0]       code;
    logic [1:0]       prof;
    logic             q, en;
    int               fail_count = 0;
    int               checks_done = 0;

    // Clock
    initial
    begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    vpt_power_cfg uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .die1_ctrl_o(die1),
        .die2_ctrl_o(die2), .chan_off_o(chan_off), .adc_power_on_o(adc_on),
        .term_sel_o(term_sel));
    vpt_host_model host (.sys_clk_i(sys_clk_i), .psel_o(psel), .penable_o(penable),
        .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata), .pready_i(pready));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish;
        if (fail_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish

    // Note the expected answer {read, err, data}, then run the transfer
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [32:0] exp);
        notes.push_back({!wr, exp});
        host.xfer(wr, a, d);
    endtask : bus

    // Answer watcher: oldest note against each completed transfer
    always @(posedge sys_clk_i)
        if (!rst_i && pready === 1'b1)
        begin
            n = notes.pop_front();
            check({31'h0, pslverr}, {31'h0, n[32]});
            if (n[33]) check(prdata, n[31:0]);
        end

    // Watchdog
    initial
    begin
        repeat (20000) @(posedge sys_clk_i);
        fail_count++;
        tally_and_finish();
    end

    // Main sequence
    initial
    begin
        rst_i = 1'b1;
        prof = 2'h0;
        void'($urandom(32'h0992));
        repeat (6) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        bus(0, PWR_CTRL_ADDR, 32'h0, 33'h0);
        bus(1, 12'h400, 32'h1, {1'b1, 32'h0});
        bus(0, 12'h400, 32'h0, {1'b1, 32'h0});
        for (int s = 0; s < 2; s++)
        begin
            bus(1, SCOPE_CTRL_ADDR, 32'(s), 33'h0);
            foreach (tbl[i])
            begin
                w = {tbl[i][15:8], 8'($urandom)};
                q = (prof == PROFILE_LOW_NOISE) ? w[9] : q;
                prof = w[11:10];
                e1 = {w[15], w[14] && !w[15], w[13], w[12], w[11:10], q};
                e2 = (s == 1) ? 7'h00 : e1;
                for (int k = 0; k < 8; k++) {ec[2*k+1], ec[2*k]} = {w[k], w[k] && s == 0};
                bus(1, PWR_CTRL_ADDR, {16'h0, w}, 33'h0);
                repeat (4) @(posedge sys_clk_i);
                #1;
                check({18'h0, die2, die1}, {18'h0, e2, e1});
                check({16'h0, chan_off}, {16'h0, ec});
                check({31'h0, adc_on}, 32'h0000_0001);
                bus(0, PWR_CTRL_ADDR, 32'h0, {17'h0, w[15:10], q, 1'b0, w[7:0]});
                bus(0, DIE_STATE_ADDR, 32'h0, {19'h0, e2, e1});
            end
        end
        for (int g = 0; g < 3; g++)
            for (int j = 0; j < 3; j++)
            begin
                code = (j == 1) ? 5'h00 : 5'($urandom_range(31, 1));
                en = (j != 0);
                bus(1, TERM_CTRL_ADDR, {17'h0, 2'(g), 7'h0, en, code}, 33'h0);
                repeat (4) @(posedge sys_clk_i);
                #1;
                check({31'h0, term_sel.active}, {31'h0, en});
                check({26'h0, term_sel.high_z, term_sel.code},
                      {26'h0, !en || code == 5'h00, en ? code : 5'h00});
                check({30'h0, term_sel.gain_row}, {30'h0, 2'(g)});
            end
        tally_and_finish();
    end
endmodule : tb_top
